// ===== design/qgt_defs.svh
`ifndef QGT_DEFS_SVH
`define QGT_DEFS_SVH

// ------------------------------------------------------------------
// Register byte offsets
// ------------------------------------------------------------------
`define QGT_GCR_OFF 8'h00
`define QGT_STAT_OFF 8'h04
`define QGT_MASK_OFF 8'h08
`define QGT_TMR_BASE 8'h10
`define QGT_TMR_STRIDE 8'h10
`define QGT_MODE_SUB 4'h0
`define QGT_REF_SUB 4'h4
`define QGT_CAP_SUB 4'h8
`define QGT_CNT_SUB 4'hC

// ------------------------------------------------------------------
// Mode register fields
// ------------------------------------------------------------------
`define QGT_M_SRC_LSB 0
`define QGT_M_TOGGLE_BIT 2
`define QGT_M_CE_LSB 3
`define QGT_M_GATE_BIT 5
`define QGT_M_GMODE_BIT 6
`define QGT_M_FRR_BIT 7
`define QGT_M_CASC_BIT 8
`define QGT_M_WIDTH 9

// ------------------------------------------------------------------
// Reset values and timing
// ------------------------------------------------------------------
`define QGT_MODE_RST 9'h000
`define QGT_REF_RST 16'hFFFF
`define QGT_PRESCALE 16
`define QGT_SLVERR 2'h2
`define QGT_OKAY 2'h0

`endif

// ===== design/qgt_pkg.sv
package qgt_pkg;
  typedef enum logic [1:0] {
    QGT_SRC_CHAIN = 2'b00,
    QGT_SRC_SYS = 2'b01,
    QGT_SRC_DIV16 = 2'b10,
    QGT_SRC_PIN = 2'b11
  } qgt_src_e;
  typedef enum logic [1:0] {
    QGT_CAP_OFF = 2'b00,
    QGT_CAP_RISE = 2'b01,
    QGT_CAP_FALL = 2'b10,
    QGT_CAP_BOTH = 2'b11
  } qgt_cap_e;
  typedef logic [15:0] qgt_cnt_t;
endpackage

// ===== design/qgt_timer_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "qgt_defs.svh"

// What this block does
// [RULE_01] Four timers, each drives its own output when count reaches reference.
// [RULE_02] Output mode per timer: active-low one-cycle pulse, or toggle on reference.
// [RULE_03] Cascade bit feeds a timer's reference event into its pair for 32 bits.
// [RULE_04] Count source: other timer, system clock, clock over 16, input pin.
// [RULE_05] Four input pins, one per timer, used as count source or capture trigger.
// [RULE_06] Capture count on input edge: rising only, falling only, or both.
// [RULE_07] Gate input either gates counting or restarts the timer, per timer config.
// [RULE_08] Gate A serves timers one and two, gate B serves three and four.
// [RULE_09] After reset timers stopped, counters cleared, outputs at inactive high level.
module qgt_timer_top (
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic [31:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [31:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic timer_in_one,
  input wire logic timer_in_two,
  input wire logic timer_in_three,
  input wire logic timer_in_four,
  input wire logic count_gate_a,
  input wire logic count_gate_b,
  output logic timer_out_one,
  output logic timer_out_two,
  output logic timer_out_three,
  output logic timer_out_four,
  output logic irq
);
  import qgt_pkg::*;

  localparam int NT = 4;

  // ------------------------------------------------------------------
  // Pin synchronisers
  // ------------------------------------------------------------------
  logic [5:0] pin_s1_r;
  logic [5:0] pin_s2_r;
  logic [5:0] pin_d_r;
  logic [NT-1:0] tin;
  logic [NT-1:0] tin_d;
  logic [NT-1:0] gate;
  logic [NT-1:0] gate_d;

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      pin_s1_r <= 6'h00;
      pin_s2_r <= 6'h00;
      pin_d_r <= 6'h00;
    end else begin
      pin_s1_r <= {count_gate_b, count_gate_a, timer_in_four, timer_in_three,
                   timer_in_two, timer_in_one};
      pin_s2_r <= pin_s1_r;
      pin_d_r <= pin_s2_r;
    end
  end

  assign tin = pin_s2_r[3:0];
  assign tin_d = pin_d_r[3:0];
  assign gate = {pin_s2_r[5], pin_s2_r[5], pin_s2_r[4], pin_s2_r[4]}; // RULE_08
  assign gate_d = {pin_d_r[5], pin_d_r[5], pin_d_r[4], pin_d_r[4]}; // RULE_08

  // ------------------------------------------------------------------
  // Prescaler by sixteen
  // ------------------------------------------------------------------
  logic [3:0] pre_r;
  logic pre_tick;

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      pre_r <= 4'h0;
    end else begin
      pre_r <= pre_r + 4'h1;
    end
  end

  assign pre_tick = (pre_r == 4'(`QGT_PRESCALE - 1)); // RULE_04

  // ------------------------------------------------------------------
  // Registers
  // ------------------------------------------------------------------
  logic [NT-1:0] run_r;
  logic [NT-1:0] stat_r;
  logic [NT-1:0] mask_r;
  logic [`QGT_M_WIDTH-1:0] mode_r [NT];
  qgt_cnt_t ref_r [NT];
  qgt_cnt_t cap_r [NT];
  qgt_cnt_t cnt_r [NT];
  logic [NT-1:0] out_r;
  logic [NT-1:0] hit;
  logic [NT-1:0] tick;
  logic [NT-1:0] cap_ev;
  logic [NT-1:0] restart;
  logic [NT-1:0] cnt_wr;
  logic [NT-1:0] stat_set;
  logic [NT-1:0] stat_clr;

  // AXI write path
  logic aw_hold_r;
  logic w_hold_r;
  logic [7:0] awaddr_r;
  logic [31:0] wdata_r;
  logic [3:0] wstrb_r;
  logic bvalid_r;
  logic wr_go;
  logic wr_map;

  assign s_axi_awready = !aw_hold_r && !bvalid_r;
  assign s_axi_wready = !w_hold_r && !bvalid_r;
  assign wr_go = aw_hold_r && w_hold_r && !bvalid_r;
  assign wr_map = (awaddr_r < 8'h50) && (awaddr_r[1:0] == 2'b00) &&
                  (awaddr_r != 8'h0C);

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      aw_hold_r <= 1'b0;
      w_hold_r <= 1'b0;
      awaddr_r <= 8'h00;
      wdata_r <= 32'h0000_0000;
      wstrb_r <= 4'h0;
      bvalid_r <= 1'b0;
      s_axi_bresp <= `QGT_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_hold_r <= 1'b1;
        awaddr_r <= s_axi_awaddr[7:0];
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_hold_r <= 1'b1;
        wdata_r <= s_axi_wdata;
        wstrb_r <= s_axi_wstrb;
      end
      if (wr_go) begin
        aw_hold_r <= 1'b0;
        w_hold_r <= 1'b0;
        bvalid_r <= 1'b1;
        s_axi_bresp <= wr_map ? `QGT_OKAY : `QGT_SLVERR;
      end else if (bvalid_r && s_axi_bready) begin
        bvalid_r <= 1'b0;
      end
    end
  end

  assign s_axi_bvalid = bvalid_r;

  // Byte-lane merge of write data into an old value
  function automatic logic [31:0] merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                        input logic [3:0] stb);
    logic [31:0] res;
    res = old_v;
    for (int b = 0; b < 4; b++) begin
      if (stb[b]) begin
        res[8*b +: 8] = new_v[8*b +: 8];
      end
    end
    return res;
  endfunction

  logic [31:0] wmask;
  assign wmask = merge(32'h0000_0000, 32'hFFFF_FFFF, wstrb_r);

  // Global, status and mask
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      run_r <= '0; // RULE_09
      mask_r <= '0;
    end else if (wr_go) begin
      if (awaddr_r == `QGT_GCR_OFF) begin
        run_r <= 4'(merge({28'h0, run_r}, wdata_r, wstrb_r));
      end
      if (awaddr_r == `QGT_MASK_OFF) begin
        mask_r <= 4'(merge({28'h0, mask_r}, wdata_r, wstrb_r));
      end
    end
  end

  assign stat_clr = (wr_go && awaddr_r == `QGT_STAT_OFF) ? (wdata_r[3:0] & wmask[3:0]) : '0;
  assign stat_set = hit | cap_ev;

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      stat_r <= '0;
    end else begin
      stat_r <= (stat_r & ~stat_clr) | stat_set;
    end
  end

  assign irq = |(stat_r & mask_r);

  // ------------------------------------------------------------------
  // Per-timer logic
  // ------------------------------------------------------------------
  for (genvar i = 0; i < NT; i++) begin : g_tmr
    localparam int PAIR = i ^ 1;
    logic [7:0] base;
    logic [`QGT_M_WIDTH-1:0] md;
    logic src_tick;
    logic en;
    logic rise;
    logic fall;
    logic cap_hit;

    assign base = 8'(`QGT_TMR_BASE + i * `QGT_TMR_STRIDE);
    assign md = mode_r[i];
    assign rise = tin[i] && !tin_d[i];
    assign fall = !tin[i] && tin_d[i];
    assign cnt_wr[i] = wr_go && awaddr_r == (base | 8'(`QGT_CNT_SUB));

    always_comb begin
      unique case (qgt_src_e'(md[`QGT_M_SRC_LSB +: 2])) // RULE_04
        QGT_SRC_CHAIN: src_tick = md[`QGT_M_CASC_BIT] && hit[PAIR]; // RULE_03
        QGT_SRC_SYS: src_tick = 1'b1;
        QGT_SRC_DIV16: src_tick = pre_tick;
        QGT_SRC_PIN: src_tick = rise; // RULE_05
      endcase
    end

    always_comb begin
      unique case (qgt_cap_e'(md[`QGT_M_CE_LSB +: 2])) // RULE_06
        QGT_CAP_OFF: cap_hit = 1'b0;
        QGT_CAP_RISE: cap_hit = rise;
        QGT_CAP_FALL: cap_hit = fall;
        QGT_CAP_BOTH: cap_hit = rise || fall;
      endcase
    end

    // Gate: level enable, or restart on gate falling edge
    assign en = !md[`QGT_M_GATE_BIT] || md[`QGT_M_GMODE_BIT] || !gate[i]; // RULE_07
    assign restart[i] = md[`QGT_M_GATE_BIT] && md[`QGT_M_GMODE_BIT] &&
                        !gate[i] && gate_d[i]; // RULE_07
    assign tick[i] = run_r[i] && en && src_tick;
    assign hit[i] = tick[i] && (cnt_r[i] == ref_r[i]); // RULE_01
    assign cap_ev[i] = run_r[i] && cap_hit;

    always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
        mode_r[i] <= `QGT_MODE_RST;
        ref_r[i] <= `QGT_REF_RST;
      end else if (wr_go) begin
        if (awaddr_r == (base | 8'(`QGT_MODE_SUB))) begin
          mode_r[i] <= `QGT_M_WIDTH'(merge({23'h0, mode_r[i]}, wdata_r, wstrb_r));
        end
        if (awaddr_r == (base | 8'(`QGT_REF_SUB))) begin
          ref_r[i] <= 16'(merge({16'h0, ref_r[i]}, wdata_r, wstrb_r));
        end
      end
    end

    always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
        cnt_r[i] <= 16'h0000; // RULE_09
      end else if (cnt_wr[i]) begin
        cnt_r[i] <= 16'(merge({16'h0, cnt_r[i]}, wdata_r, wstrb_r));
      end else if (restart[i] || !run_r[i]) begin
        cnt_r[i] <= 16'h0000;
      end else if (hit[i] && md[`QGT_M_FRR_BIT]) begin
        cnt_r[i] <= 16'h0000;
      end else if (tick[i]) begin
        cnt_r[i] <= cnt_r[i] + 16'h0001;
      end
    end

    always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
        cap_r[i] <= 16'h0000;
      end else if (cap_ev[i]) begin
        cap_r[i] <= cnt_r[i]; // RULE_06
      end
    end

    always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
        out_r[i] <= 1'b1; // RULE_09
      end else if (!run_r[i]) begin
        out_r[i] <= 1'b1;
      end else if (md[`QGT_M_TOGGLE_BIT]) begin
        out_r[i] <= hit[i] ? !out_r[i] : out_r[i]; // RULE_02
      end else begin
        out_r[i] <= !hit[i]; // RULE_02
      end
    end

    a_pulse_low: assert property (@(posedge sys_clk) disable iff (!rstn)
      (run_r[i] && !md[`QGT_M_TOGGLE_BIT] && hit[i]) |=> !out_r[i]) // RULE_02
      else $error("pulse mode output not low after reference hit");
    a_toggle_flip: assert property (@(posedge sys_clk) disable iff (!rstn)
      (run_r[i] && md[`QGT_M_TOGGLE_BIT] && hit[i]) |=> (out_r[i] != $past(out_r[i]))) // RULE_02
      else $error("toggle mode output did not invert");
    a_stop_clear: assert property (@(posedge sys_clk) disable iff (!rstn)
      (!run_r[i] && !cnt_wr[i]) |=> (cnt_r[i] == 16'h0000 && out_r[i])) // RULE_09
      else $error("stopped timer not cleared");
    a_capture_val: assert property (@(posedge sys_clk) disable iff (!rstn)
      cap_ev[i] |=> (cap_r[i] == $past(cnt_r[i]))) // RULE_06
      else $error("capture register wrong");
    a_gate_hold: assert property (@(posedge sys_clk) disable iff (!rstn)
      (md[`QGT_M_GATE_BIT] && !md[`QGT_M_GMODE_BIT] && gate[i] && !cnt_wr[i] && run_r[i])
      |=> $stable(cnt_r[i])) // RULE_07
      else $error("gated timer counted while gate high");
    a_gate_restart: assert property (@(posedge sys_clk) disable iff (!rstn)
      (restart[i] && !cnt_wr[i]) |=> cnt_r[i] == 16'h0000) // RULE_07
      else $error("gate restart did not clear count");
  end

  a_cascade_tick: assert property (@(posedge sys_clk) disable iff (!rstn)
    (run_r[1] && mode_r[1][`QGT_M_SRC_LSB +: 2] == 2'b00 && mode_r[1][`QGT_M_CASC_BIT]
     && !gate[1] && !mode_r[1][`QGT_M_GATE_BIT]) |-> (tick[1] == hit[0])) // RULE_03
    else $error("cascaded timer did not follow its pair");
  a_div_spacing: assert property (@(posedge sys_clk) disable iff (!rstn)
    pre_tick |=> !pre_tick [*8]) // RULE_04
    else $error("prescaler ticks too close");

  assign timer_out_one = out_r[0]; // RULE_01
  assign timer_out_two = out_r[1];
  assign timer_out_three = out_r[2];
  assign timer_out_four = out_r[3];

  // ------------------------------------------------------------------
  // AXI read path
  // ------------------------------------------------------------------
  logic rvalid_r;
  logic [31:0] rd_v;
  logic rd_ok;
  logic [7:0] ra;
  logic [1:0] ri;

  assign s_axi_arready = !rvalid_r;
  assign ra = s_axi_araddr[7:0];
  assign ri = 2'((ra - 8'h10) >> 4);

  always_comb begin
    rd_v = 32'h0000_0000;
    rd_ok = (ra[1:0] == 2'b00);
    if (ra == `QGT_GCR_OFF) begin
      rd_v = {28'h0, run_r};
    end else if (ra == `QGT_STAT_OFF) begin
      rd_v = {28'h0, stat_r};
    end else if (ra == `QGT_MASK_OFF) begin
      rd_v = {28'h0, mask_r};
    end else if (ra >= `QGT_TMR_BASE && ra < 8'h50) begin
      unique case (ra[3:0])
        `QGT_MODE_SUB: rd_v = {23'h0, mode_r[ri]};
        `QGT_REF_SUB: rd_v = {16'h0, ref_r[ri]};
        `QGT_CAP_SUB: rd_v = {16'h0, cap_r[ri]};
        `QGT_CNT_SUB: rd_v = {16'h0, cnt_r[ri]};
        default: rd_ok = 1'b0;
      endcase
    end else begin
      rd_ok = 1'b0;
    end
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      rvalid_r <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= `QGT_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      rvalid_r <= 1'b1;
      s_axi_rdata <= rd_ok ? rd_v : 32'h0000_0000;
      s_axi_rresp <= rd_ok ? `QGT_OKAY : `QGT_SLVERR;
    end else if (rvalid_r && s_axi_rready) begin
      rvalid_r <= 1'b0;
    end
  end

  assign s_axi_rvalid = rvalid_r;

endmodule
`default_nettype wire

// ===== tb/qgt_pins_model.sv
`timescale 1ns/1ps
`default_nettype none

// ------------------------------------------------------------------
// External timer input and gate pins
// ------------------------------------------------------------------
module qgt_pins_model (
  input wire logic sys_clk,
  output logic [3:0] tin,
  output logic gate_a,
  output logic gate_b
);
  // Pins idle low from time zero
  initial begin
    tin = 4'h0;
    gate_a = 1'b0;
    gate_b = 1'b0;
  end

  // One input pin per timer, held three cycles
  task automatic set_pin(input int i, input logic v);
    @(posedge sys_clk);
    tin <= v ? (tin | (4'h1 << i)) : (tin & ~(4'h1 << i));
    repeat (3) @(posedge sys_clk);
  endtask

  task automatic pulses(input int i, input int n);
    repeat (n) begin
      set_pin(i, 1'b1);
      set_pin(i, 1'b0);
    end
  endtask

  // Gate A for the first pair, gate B for the second
  task automatic set_gate(input int b, input logic v);
    @(posedge sys_clk);
    if (b == 1) gate_b <= v;
    else gate_a <= v;
    repeat (3) @(posedge sys_clk);
  endtask
endmodule
`default_nettype wire

// ===== tb/quad_general_timer_test.sv
`timescale 1ns/1ps
`default_nettype none
`include "qgt_defs.svh"

module quad_general_timer_test;
  import qgt_pkg::*;
  logic sys_clk = 1'b0;
  logic rstn = 1'b0;
  logic [31:0] aw_a = '0, w_d = '0, ar_a = '0, r_d;
  logic aw_v = 1'b0, w_v = 1'b0, b_r = 1'b0, ar_v = 1'b0, r_r = 1'b0;
  logic aw_r, w_r, b_v, ar_r, r_v, irq;
  logic [1:0] b_rs, r_rs, wresp;
  logic [3:0] tin, outs;
  logic gate_a, gate_b, o1, o2, o3, o4;
  int errors = 0;
  int num_checks = 0;
  assign outs = {o4, o3, o2, o1};

  always #2 sys_clk = ~sys_clk;

  qgt_timer_top qgt_timer_top_i (.sys_clk(sys_clk), .rstn(rstn),
    .s_axi_awaddr(aw_a), .s_axi_awvalid(aw_v), .s_axi_awready(aw_r),
    .s_axi_wdata(w_d), .s_axi_wstrb(4'hF), .s_axi_wvalid(w_v), .s_axi_wready(w_r),
    .s_axi_bresp(b_rs), .s_axi_bvalid(b_v), .s_axi_bready(b_r),
    .s_axi_araddr(ar_a), .s_axi_arvalid(ar_v), .s_axi_arready(ar_r),
    .s_axi_rdata(r_d), .s_axi_rresp(r_rs), .s_axi_rvalid(r_v), .s_axi_rready(r_r),
    .timer_in_one(tin[0]), .timer_in_two(tin[1]), .timer_in_three(tin[2]),
    .timer_in_four(tin[3]), .count_gate_a(gate_a), .count_gate_b(gate_b),
    .timer_out_one(o1), .timer_out_two(o2), .timer_out_three(o3),
    .timer_out_four(o4), .irq(irq));

  qgt_pins_model qgt_pins_model_i (.sys_clk(sys_clk), .tin(tin), .gate_a(gate_a),
    .gate_b(gate_b));

  // ------------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------------
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic final_report();
    $display("Checks %0d mismatches %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic ao, wo;
    ao = 1'b0;
    wo = 1'b0;
    @(posedge sys_clk);
    aw_a <= {24'h000000, a};
    w_d <= d;
    aw_v <= 1'b1;
    w_v <= 1'b1;
    b_r <= 1'b1;
    while (!(ao && wo)) begin
      @(posedge sys_clk);
      if (aw_v === 1'b1 && aw_r === 1'b1) begin
        ao = 1'b1;
        aw_v <= 1'b0;
      end
      if (w_v === 1'b1 && w_r === 1'b1) begin
        wo = 1'b1;
        w_v <= 1'b0;
      end
    end
    while (b_v !== 1'b1) @(posedge sys_clk);
    wresp = b_rs;
    b_r <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] rs);
    @(posedge sys_clk);
    ar_a <= {24'h000000, a};
    ar_v <= 1'b1;
    r_r <= 1'b1;
    do @(posedge sys_clk); while (ar_r !== 1'b1);
    ar_v <= 1'b0;
    while (r_v !== 1'b1) @(posedge sys_clk);
    r_r <= 1'b0;
    d = r_d;
    rs = r_rs;
  endtask

  function automatic logic [7:0] ta(input int n, input logic [3:0] sub);
    return 8'(`QGT_TMR_BASE + n * `QGT_TMR_STRIDE + sub);
  endfunction

  function automatic logic [31:0] mw(input int s, t, c, g, m, f, k);
    return 32'((s << `QGT_M_SRC_LSB) | (t << `QGT_M_TOGGLE_BIT) | (c << `QGT_M_CE_LSB)
      | (g << `QGT_M_GATE_BIT) | (m << `QGT_M_GMODE_BIT) | (f << `QGT_M_FRR_BIT)
      | (k << `QGT_M_CASC_BIT));
  endfunction

  // Cycles until the output of timer n changes
  task automatic wait_edge(input int n, output int cyc);
    logic p;
    p = outs[n];
    cyc = 0;
    do begin
      @(posedge sys_clk);
      cyc++;
    end while (outs[n] === p && cyc < 5000);
  endtask

  // ------------------------------------------------------------------
  // Tests
  // ------------------------------------------------------------------
  initial begin
    int r, k, d1, d2, cap;
    logic [31:0] v, v1;
    logic [1:0] rs;
    void'($urandom(97));
    repeat (2) @(posedge sys_clk);
    rstn <= 1'b1;
    @(posedge sys_clk);
    check("idle outputs", {28'h0, outs}, 32'hF);
    for (int n = 0; n < 4; n++) begin
      rd(ta(n, `QGT_REF_SUB), v, rs);
      check("ref reset", v, 32'h0000FFFF);
      rd(ta(n, `QGT_CNT_SUB), v, rs);
      check("count reset", v, 32'h0);
    end
    rd(8'h0C, v, rs);
    check("unmapped resp", {30'h0, rs}, {30'h0, `QGT_SLVERR});
    wr(8'h0C, 32'h0);
    check("unmapped write resp", {30'h0, wresp}, {30'h0, `QGT_SLVERR});
    wr(`QGT_MASK_OFF, 32'h0);
    check("mapped write resp", {30'h0, wresp}, {30'h0, `QGT_OKAY});
    // Pulse and toggle per timer
    for (int n = 0; n < 4; n++) begin
      for (int t = 0; t < 2; t++) begin
        r = 2 + $urandom % 20;
        wr(ta(n, `QGT_REF_SUB), r);
        wr(ta(n, `QGT_MODE_SUB), mw(1, t, 0, 0, 0, 1, 0));
        wr(`QGT_MASK_OFF, 32'h1 << n);
        wr(`QGT_GCR_OFF, 32'h1 << n);
        wait_edge(n, d1);
        check("out after hit", {31'h0, outs[n]}, 32'h0);
        wait_edge(n, d1);
        wait_edge(n, d2);
        check("first span", d1, t ? r + 1 : 1);
        check("second span", d2, t ? r + 1 : r);
        check("irq on hit", {31'h0, irq}, 32'h1);
        wr(`QGT_GCR_OFF, 32'h0);
        wr(`QGT_STAT_OFF, 32'hF);
        @(posedge sys_clk);
        check("irq cleared", {31'h0, irq}, 32'h0);
        check("out stopped", {31'h0, outs[n]}, 32'h1);
      end
    end
    // Capture edges
    for (int n = 0; n < 4; n++) begin
      cap = (n % 3) + 1;
      wr(ta(n, `QGT_MODE_SUB), mw(1, 0, cap, 0, 0, 0, 0));
      wr(`QGT_GCR_OFF, 32'h1 << n);
      wr(`QGT_STAT_OFF, 32'hF);
      qgt_pins_model_i.set_pin(n, 1'b1);
      rd(`QGT_STAT_OFF, v, rs);
      check("rise capture", {31'h0, v[n]}, cap & 1);
      wr(`QGT_STAT_OFF, 32'hF);
      qgt_pins_model_i.set_pin(n, 1'b0);
      rd(`QGT_STAT_OFF, v, rs);
      check("fall capture", {31'h0, v[n]}, cap >> 1);
      rd(ta(n, `QGT_CAP_SUB), v, rs);
      check("capture held", v != 0, 1);
      wr(`QGT_GCR_OFF, 32'h0);
      // Pin as count source
      k = 1 + $urandom % 5;
      wr(ta(n, `QGT_MODE_SUB), mw(3, 0, 0, 0, 0, 0, 0));
      wr(`QGT_GCR_OFF, 32'h1 << n);
      qgt_pins_model_i.pulses(n, k);
      rd(ta(n, `QGT_CNT_SUB), v, rs);
      check("pin count", v, k);
      wr(`QGT_GCR_OFF, 32'h0);
    end
    // Clock over sixteen
    k = $urandom % 4;
    wr(ta(k, `QGT_MODE_SUB), mw(2, 0, 0, 0, 0, 0, 0));
    wr(`QGT_GCR_OFF, 32'h1 << k);
    repeat (160) @(posedge sys_clk);
    rd(ta(k, `QGT_CNT_SUB), v, rs);
    check("div16 count", v >= 9 && v <= 12, 1);
    wr(`QGT_GCR_OFF, 32'h0);
    // Gate and restart
    for (int g = 0; g < 2; g++) begin
      k = 2 * g + 1;
      wr(ta(k, `QGT_MODE_SUB), mw(1, 0, 0, 1, 0, 0, 0));
      qgt_pins_model_i.set_gate(g, 1'b1);
      wr(`QGT_GCR_OFF, 32'h1 << k);
      rd(ta(k, `QGT_CNT_SUB), v, rs);
      rd(ta(k, `QGT_CNT_SUB), v1, rs);
      check("gated hold", v1, v);
      qgt_pins_model_i.set_gate(g, 1'b0);
      rd(ta(k, `QGT_CNT_SUB), v1, rs);
      check("ungated run", v1 != v, 1);
      wr(ta(k, `QGT_MODE_SUB), mw(1, 0, 0, 1, 1, 0, 0));
      qgt_pins_model_i.set_gate(g, 1'b1);
      repeat (30) @(posedge sys_clk);
      qgt_pins_model_i.set_gate(g, 1'b0);
      rd(ta(k, `QGT_CNT_SUB), v, rs);
      check("restart", v < 16, 1);
      wr(`QGT_GCR_OFF, 32'h0);
    end
    // Cascade pair
    r = 3 + $urandom % 8;
    wr(ta(0, `QGT_REF_SUB), r);
    wr(ta(0, `QGT_MODE_SUB), mw(1, 0, 0, 0, 0, 1, 0));
    wr(ta(1, `QGT_MODE_SUB), mw(0, 0, 0, 0, 0, 0, 1));
    wr(`QGT_GCR_OFF, 32'h3);
    repeat (10 * (r + 1)) @(posedge sys_clk);
    rd(ta(1, `QGT_CNT_SUB), v, rs);
    check("cascade count", v >= 9 && v <= 11, 1);
    wr(`QGT_GCR_OFF, 32'h0);
    rd(ta(1, `QGT_CNT_SUB), v, rs);
    check("stop clears", v, 32'h0);
    final_report();
  end

  initial begin
    #200000;
    errors++;
    final_report();
  end
endmodule
`default_nettype wire
